// >>> logic/timer8_defines.svh
// Register indices, field positions, reset values and limits of the timer
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH
// Register indices; byte address is four times the index
`define IDX_CTRL_A 8'h24
`define IDX_CTRL_B 8'h25
`define IDX_COUNT 8'h26
`define IDX_CMP_A 8'h27
`define IDX_CMP_B 8'h28
`define IDX_FLAGS 8'h2A
// Field positions
`define ACT_A_HI 7
`define ACT_A_LO 6
`define ACT_B_HI 5
`define ACT_B_LO 4
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6
`define MODE_HI_BIT 3
`define FLAG_OVF_BIT 0
`define FLAG_A_BIT 1
`define FLAG_B_BIT 2
// Writable bits and reset values
`define CTRL_A_MASK 8'hF3
`define REG_RESET 8'h00
// Counter limits
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
// Prescaler tap masks for divide by 8, 64, 256 and 1024
`define PRE_DIV8 10'h007
`define PRE_DIV64 10'h03F
`define PRE_DIV256 10'h0FF
`define PRE_DIV1024 10'h3FF
`endif

// >>> logic/timer8_pkg.sv
// Types shared by the timer control logic
`default_nettype none
package timer8_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PC_FF = 3'b001,
    MODE_CLR_MATCH = 3'b010,
    MODE_FAST_FF = 3'b011,
    MODE_RSV4 = 3'b100,
    MODE_PC_A = 3'b101,
    MODE_RSV6 = 3'b110,
    MODE_FAST_A = 3'b111
  } mode_t;
  typedef enum logic [2:0] {
    CLK_STOP = 3'b000,
    CLK_DIV1 = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV64 = 3'b011,
    CLK_DIV256 = 3'b100,
    CLK_DIV1024 = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_RISE = 3'b111
  } clk_sel_t;
endpackage : timer8_pkg
`default_nettype wire

// >>> logic/timer8_ctrl.sv
// 8-bit timer: mode, output action, force compare and clock select
//
// The APB slave port was left to the implementer.
`include "timer8_defines.svh"
`default_nettype none
module timer8_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic ext_count_pin_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic waveform_out_a_out,
  output logic wave_a_drive_out,
  output logic waveform_out_b_out,
  output logic wave_b_drive_out
);
  import timer8_pkg::*;

  logic [7:0] ctrl_a_q, count_q, cmp_a_q, cmp_b_q, buf_a_q, buf_b_q;
  logic [9:0] pre_q;
  logic mode_hi_q, dir_up_q, block_q, ovf_q, flag_a_q, flag_b_q;
  logic wave_a_q, wave_b_q, drive_a_q, drive_b_q;
  logic sync1_q, sync2_q, sync3_q, pready_q, slverr_q;
  logic [31:0] prdata_q;
  clk_sel_t clk_sel_q;
  logic tick;
  logic [7:0] count_d;
  logic dir_d;

  // Output action per channel; one function for A and B, but only A gets the PWM toggle (tog_ok from mode_hi_q)
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
      input logic fast, input logic pc, input logic up, input logic hit,
      input logic bot, input logic top_ev, input logic ocr_top,
      input logic tog_ok);
    wave_next = cur;
    if (!fast && !pc) begin
      if (hit) begin
        case (act)
          2'b01: wave_next = ~cur;
          2'b10: wave_next = 1'b0;
          2'b11: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
    end else if (act[1]) begin
      if (fast) begin
        if (bot) begin
          wave_next = ~act[0];
        end else if (hit && !ocr_top) begin
          wave_next = act[0];
        end else if (top_ev && ocr_top) begin
          wave_next = ~act[0];
        end
      end else begin
        if (hit && !ocr_top) begin
          wave_next = up ? act[0] : ~act[0];
        end else if (top_ev && ocr_top) begin
          wave_next = ~act[0];
        end
      end
    end else if (act == 2'b01 && tog_ok && hit) begin
      wave_next = ~cur;
    end
  endfunction : wave_next

  // Bus decode; printed offsets are indices, so drop two address bits
  wire [7:0] word_idx = paddr_in[9:2];
  wire aligned = (paddr_in[11:10] == 2'b00) && (paddr_in[1:0] == 2'b00);
  wire hit_ca = aligned && (word_idx == `IDX_CTRL_A);
  wire hit_cb = aligned && (word_idx == `IDX_CTRL_B);
  wire hit_cnt = aligned && (word_idx == `IDX_COUNT);
  wire hit_oa = aligned && (word_idx == `IDX_CMP_A);
  wire hit_ob = aligned && (word_idx == `IDX_CMP_B);
  wire hit_fl = aligned && (word_idx == `IDX_FLAGS);
  wire mapped = hit_ca | hit_cb | hit_cnt | hit_oa | hit_ob | hit_fl;
  wire setup = psel_in & ~penable_in;
  wire wr = psel_in & penable_in & pwrite_in & pready_q;
  wire [7:0] wbyte = pwdata_in[7:0];

  wire [2:0] mode = {mode_hi_q, ctrl_a_q[1:0]};
  wire is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_A);
  wire is_pc = (mode == MODE_PC_FF) || (mode == MODE_PC_A);
  wire is_pwm = is_fast | is_pc;
  wire top_a = (mode == MODE_CLR_MATCH) || (mode == MODE_PC_A) ||
               (mode == MODE_FAST_A);
  wire [7:0] top = top_a ? cmp_a_q : `CNT_MAX;
  wire at_top = (count_q == top);
  wire at_bot = (count_q == `CNT_BOTTOM);
  wire [1:0] act_a = ctrl_a_q[`ACT_A_HI:`ACT_A_LO];
  wire [1:0] act_b = ctrl_a_q[`ACT_B_HI:`ACT_B_LO];

  // Pin edges after two sync stages; third stage only remembers
  wire ext_rise = sync2_q & ~sync3_q;
  wire ext_fall = ~sync2_q & sync3_q;

  always_comb begin
    case (clk_sel_q)
      CLK_STOP: tick = 1'b0;
      CLK_DIV1: tick = 1'b1;
      CLK_DIV8: tick = (pre_q & `PRE_DIV8) == `PRE_DIV8;
      CLK_DIV64: tick = (pre_q & `PRE_DIV64) == `PRE_DIV64;
      CLK_DIV256: tick = (pre_q & `PRE_DIV256) == `PRE_DIV256;
      CLK_DIV1024: tick = pre_q == `PRE_DIV1024;
      CLK_EXT_FALL: tick = ext_fall;
      CLK_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Matches; a counter write hides the next one
  wire mt_a = tick & ~block_q & (count_q == cmp_a_q);
  wire mt_b = tick & ~block_q & (count_q == cmp_b_q);
  wire frc_a = wr & hit_cb & wbyte[`FORCE_A_BIT] & ~is_pwm;
  wire frc_b = wr & hit_cb & wbyte[`FORCE_B_BIT] & ~is_pwm;
  wire top_ev = tick & at_top;
  wire bot_ev = tick & at_bot;

  // counter stepped only by the enable
  always_comb begin
    count_d = count_q;
    dir_d = dir_up_q;
    if (tick) begin
      if (is_pc) begin
        if (dir_up_q) begin
          dir_d = !at_top;
          count_d = at_top ? count_q - 8'h01 : count_q + 8'h01;
        end else begin
          dir_d = at_bot;
          count_d = at_bot ? count_q + 8'h01 : count_q - 8'h01;
        end
      // only a real TOP match clears
      end else if (top_a || is_fast) begin
        count_d = at_top ? `CNT_BOTTOM : count_q + 8'h01;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  // overflow at MAX in normal and match-clear
  // overflow at BOTTOM in phase correct
  // overflow at TOP in fast mode 7
  wire ovf_ev = is_pc ? bot_ev :
                (mode == MODE_FAST_A) ? top_ev :
                (tick && count_q == `CNT_MAX);
  wire cmp_upd = !is_pwm || (is_pc ? top_ev : bot_ev);
  wire clr_ovf = wr & hit_fl & wbyte[`FLAG_OVF_BIT];
  wire clr_a = wr & hit_fl & wbyte[`FLAG_A_BIT];
  wire clr_b = wr & hit_fl & wbyte[`FLAG_B_BIT];

  wire [7:0] rd_byte =
    hit_ca ? (ctrl_a_q & `CTRL_A_MASK) :
    hit_cb ? {4'h0, mode_hi_q, clk_sel_q} :
    hit_cnt ? count_q :
    hit_oa ? buf_a_q :
    hit_ob ? buf_b_q :
    hit_fl ? {5'h00, flag_b_q, flag_a_q, ovf_q} : 8'h00;

  wire drive_a_d = (act_a != 2'b00) &&
                   !(is_pwm && act_a == 2'b01 && !mode_hi_q);
  wire drive_b_d = (act_b != 2'b00);

  // Bus slave: no wait state, answer and data from flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      slverr_q <= setup & ~mapped;
      prdata_q <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Control and compare registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_a_q <= `REG_RESET;
      mode_hi_q <= 1'b0;
      clk_sel_q <= CLK_STOP;
      buf_a_q <= `REG_RESET;
      buf_b_q <= `REG_RESET;
      cmp_a_q <= `REG_RESET;
      cmp_b_q <= `REG_RESET;
    end else begin
      if (wr && hit_ca) ctrl_a_q <= wbyte & `CTRL_A_MASK;
      if (wr && hit_cb) begin
        mode_hi_q <= wbyte[`MODE_HI_BIT];
        clk_sel_q <= clk_sel_t'(wbyte[2:0]);
      end
      if (wr && hit_oa) buf_a_q <= wbyte;
      if (wr && hit_ob) buf_b_q <= wbyte;
      if (cmp_upd) begin
        cmp_a_q <= buf_a_q;
        cmp_b_q <= buf_b_q;
      end
    end
  end

  // Counter, prescaler and pin synchroniser
  // pin sampled whatever its direction
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= `CNT_BOTTOM;
      dir_up_q <= 1'b1;
      block_q <= 1'b0;
      pre_q <= 10'h000;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      count_q <= (wr && hit_cnt) ? wbyte : count_d;
      dir_up_q <= dir_d;
      block_q <= (wr && hit_cnt) | (block_q & ~tick);
      pre_q <= pre_q + 10'h001;
      sync1_q <= ext_count_pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Flags: a new event beats a clear in the same cycle
  // force strobes do not touch flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ovf_q <= 1'b0;
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
    end else begin
      ovf_q <= ovf_ev | (ovf_q & ~clr_ovf);
      flag_a_q <= mt_a | (flag_a_q & ~clr_a);
      flag_b_q <= mt_b | (flag_b_q & ~clr_b);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      drive_a_q <= 1'b0;
      drive_b_q <= 1'b0;
    end else begin
      wave_a_q <= wave_next(wave_a_q, act_a, is_fast, is_pc, dir_up_q,
                            mt_a | frc_a, bot_ev, top_ev,
                            cmp_a_q == top, mode_hi_q);
      wave_b_q <= wave_next(wave_b_q, act_b, is_fast, is_pc, dir_up_q,
                            mt_b | frc_b, bot_ev, top_ev,
                            cmp_b_q == top, 1'b0);
      drive_a_q <= drive_a_d;
      drive_b_q <= drive_b_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = slverr_q;
  assign waveform_out_a_out = wave_a_q;
  assign waveform_out_b_out = wave_b_q;
  assign wave_a_drive_out = drive_a_q;
  assign wave_b_drive_out = drive_b_q;

  // Checks on the waveform, clock, counter, flag and register read-back logic
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_drive_b;
    act_b != 2'b00 |=> wave_b_drive_out;
  endproperty
  a_drive_b: assert property (p_drive_b)
    else $error("pin B not taken by action");
  property p_nonpwm_set;
    (!is_pwm && act_b == 2'b11 && (mt_b || frc_b)) |=> wave_b_q;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set)
    else $error("B not set on match");
  property p_fast_bottom;
    (is_fast && act_b == 2'b10 && bot_ev) |=> wave_b_q;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("fast PWM B not set at bottom");
  property p_pc_up;
    (is_pc && act_b == 2'b10 && mt_b && dir_up_q && cmp_b_q != top)
      |=> !wave_b_q;
  endproperty
  a_pc_up: assert property (p_pc_up)
    else $error("phase correct B not cleared going up");
  property p_resv;
    (setup && hit_cb) |=> prdata_q[7:4] == 4'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved or force bits read nonzero");
  property p_match_clear;
    (mode == MODE_CLR_MATCH && mt_a && !(wr && hit_cnt))
      |=> count_q == `CNT_BOTTOM;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("counter not cleared on A match");
  property p_ovf_pc;
    (is_pc && bot_ev) |=> ovf_q;
  endproperty
  a_ovf_pc: assert property (p_ovf_pc)
    else $error("overflow not set at bottom");
  property p_pwm_force;
    (is_pwm && !tick) |=> $stable(wave_b_q);
  endproperty
  a_pwm_force: assert property (p_pwm_force)
    else $error("B moved without timer clock in PWM");
  property p_force_noflag;
    (frc_b && !mt_b && !clr_b) |=> flag_b_q == $past(flag_b_q);
  endproperty
  a_force_noflag: assert property (p_force_noflag)
    else $error("force strobe changed B flag");
  property p_stop;
    (clk_sel_q == CLK_STOP && !(wr && hit_cnt)) |=> $stable(count_q);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");
  property p_ext_rise;
    (clk_sel_q == CLK_EXT_RISE && sync2_q && !sync3_q) |-> tick;
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising pin edge did not count");
endmodule : timer8_ctrl
`default_nettype wire

// >>> sim/pin_side_model.sv
// Far-side model: external count source and the channel B port pin
`default_nettype none
module pin_side_model (
  input wire logic clk_in,
  input wire logic wave_b_in,
  input wire logic drive_b_in,
  input wire logic dir_out_in,
  output logic count_pin_out,
  output logic pin_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // direction gates driver
  // An undriven pin floats to its pull-up level
  assign pin_b_out = (dir_out_in && drive_b_in) ? wave_b_in : 1'b1;
  initial count_pin_out = 1'b0;
  // pin pulses counted
  // Slow pulses, so each level outlives the input synchroniser
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_in);
      count_pin_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      count_pin_out <= 1'b0;
    end
  endtask : pulses
endmodule : pin_side_model
`default_nettype wire

// >>> sim/tb_timer8_ctrl.sv
// Register-level bench of the timer control block
`include "timer8_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) \
  begin checks_done++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_timer8_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, wave_a, drive_a, wave_b, drive_b;
  logic ext_pin, pin_b;
  logic [7:0] q;
  logic e;
  logic w0;
  int fails = 0;
  int checks_done = 0;
  int h;
  int dv[6] = '{0, 1, 8, 64, 256, 1024};
  int md[7] = '{3, 3, 1, 7, 5, 3, 1};
  int ac[7] = '{2, 3, 2, 2, 2, 2, 2};
  int ca[7] = '{0, 0, 0, 63, 63, 0, 0};
  int cb[7] = '{128, 128, 64, 32, 16, 255, 255};
  int ex[7] = '{516, 508, 255, 528, 260, 1024, 1024};
  int tl[7] = '{16, 16, 16, 24, 24, 2, 2};
  localparam logic [11:0] A_CA = {2'b00, `IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_CB = {2'b00, `IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_CN = {2'b00, `IDX_COUNT, 2'b00};
  localparam logic [11:0] A_MA = {2'b00, `IDX_CMP_A, 2'b00};
  localparam logic [11:0] A_MB = {2'b00, `IDX_CMP_B, 2'b00};
  localparam logic [11:0] A_FL = {2'b00, `IDX_FLAGS, 2'b00};

  // 40 MHz clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  timer8_ctrl i_timer8_ctrl (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .ext_count_pin_in(ext_pin),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .waveform_out_a_out(wave_a), .wave_a_drive_out(drive_a),
    .waveform_out_b_out(wave_b), .wave_b_drive_out(drive_b));

  pin_side_model i_pin_side_model (.clk_in(clk_in), .wave_b_in(wave_b),
    .drive_b_in(drive_b), .dir_out_in(1'b1), .count_pin_out(ext_pin),
    .pin_b_out(pin_b));

  // One APB transfer; waits on pready, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake
  initial begin
    cyc(95000);
    fails++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, A_CA + 12'(4 * i), 8'h00);
      `CHK("reset value", 8'h00, q)
    end
    apb(1'b0, 12'h0A4, 8'h00);
    `CHK("unmapped error", 1'b1, e)
    apb(1'b1, A_CA, 8'hFF);
    apb(1'b0, A_CA, 8'h00);
    `CHK("ctrl_a reserved", 8'hF3, q)
    apb(1'b1, A_CB, 8'hF0);
    apb(1'b0, A_CB, 8'h00);
    `CHK("ctrl_b reserved", 8'h00, q)
    // Forced matches in normal mode with the counter stopped
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CA, 8'(((i == 0) ? 3 : (i == 1) ? 2 : 1) << 4));
      apb(1'b1, A_CB, 8'h40);
      cyc(2);
      `CHK("forced level", 1'(~i & 1), wave_b)
      `CHK("pin takeover", 1'b1, drive_b)
    end
    apb(1'b0, A_CB, 8'h00);
    `CHK("force reads zero", 8'h00, q)
    apb(1'b0, A_FL, 8'h00);
    `CHK("no flag on force", 8'h00, q)
    apb(1'b1, A_CA, 8'h00);
    cyc(2);
    `CHK("pin released", 1'b0, drive_b)
    // Channel A forced set in normal mode, then channel B force ignored in fast PWM
    apb(1'b1, A_CA, 8'hC0);
    apb(1'b1, A_CB, 8'h80);
    cyc(2);
    `CHK("forced level A", 1'b1, wave_a)
    `CHK("pin takeover A", 1'b1, drive_a)
    apb(1'b1, A_CA, 8'h33);
    cyc(2);
    w0 = wave_b;
    apb(1'b1, A_CB, 8'h40);
    cyc(2);
    `CHK("force ignored", w0, wave_b)
    // Overflow at MAX in normal mode, then clear
    apb(1'b1, A_CA, 8'h00);
    apb(1'b1, A_CN, 8'hFC);
    apb(1'b1, A_CB, 8'h01);
    cyc(10);
    apb(1'b1, A_CB, 8'h00);
    apb(1'b0, A_FL, 8'h00);
    `CHK("overflow at MAX", 1'b1, q[`FLAG_OVF_BIT])
    apb(1'b1, A_FL, 8'h07);
    apb(1'b1, A_CA, 8'h02);
    apb(1'b1, A_MA, 8'h05);
    apb(1'b1, A_CN, 8'h00);
    apb(1'b1, A_CB, 8'h01);
    cyc(50);
    apb(1'b1, A_CB, 8'h00);
    apb(1'b0, A_CN, 8'h00);
    `CHK("clear on match top", 1'b1, q <= 8'h05)
    apb(1'b0, A_FL, 8'h00);
    `CHK("no overflow below MAX", 1'b0, q[`FLAG_OVF_BIT])
    // Internal clock selects, window allows transfer slack
    apb(1'b1, A_CA, 8'h00);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, A_CN, 8'h00);
      apb(1'b1, A_CB, 8'(c));
      cyc((c == 0) ? 40 : 40 * dv[c]);
      apb(1'b1, A_CB, 8'h00);
      apb(1'b0, A_CN, 8'h00);
      w0 = (c == 0) ? (q == 8'h00) : (q > 8'h26 && q < 8'h2D);
      `CHK("prescaled count", 1'b1, w0)
    end
    // External edges on the count pin
    for (int c = 6; c < 8; c++) begin
      apb(1'b1, A_CN, 8'h00);
      apb(1'b1, A_CB, 8'(c));
      i_pin_side_model.pulses(5);
      cyc(8);
      apb(1'b1, A_CB, 8'h00);
      apb(1'b0, A_CN, 8'h00);
      `CHK("pin edge count", 8'h05, q)
    end
    // PWM duty on the pin across modes, codes and compare at TOP
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, A_CB, 8'h00);
      apb(1'b1, A_CN, 8'h00);
      apb(1'b1, A_MA, 8'(ca[i]));
      apb(1'b1, A_MB, 8'(cb[i]));
      apb(1'b1, A_CA, 8'((ac[i] << 4) | (md[i] & 3)));
      apb(1'b1, A_CB, 8'(((md[i] >> 2) << 3) | 1));
      cyc(600);
      h = 0;
      repeat (1024) begin
        @(posedge clk_in);
        h += int'(pin_b);
      end
      `CHK("pwm duty", 1'b1, h >= ex[i] - tl[i] && h <= ex[i] + tl[i])
    end
    complete_run();
  end
endmodule : tb_timer8_ctrl
`default_nettype wire
